//--- shared/timer_pkg.sv
// Constants, register map and carrier types of the general purpose timer.
// Assumes a 32-bit AXI4-Lite master and one 200 MHz clock.
// Function
// - Edge-time mode runs without the prescaler
// - Edge-time counts down freely from interval load
// - Edge-time selected by capture select 1, mode 3
// - Edge-count selected by capture select 0, mode 3
// - Capture edge chosen as rising, falling or both
// - Edge-time counter reloads at zero, keeps running
// - Captured count held until next selected edge
// - Edge-time load write applies next cycle
// - PWM selected by alternate 1, capture 0, mode 2
// - PWM counts down, reloads after zero, repeats
// - PWM mode never sets status flags
// - PWM rises at load value, falls at match
// - Output level bit inverts the PWM output
// - PWM load write changes period next cycle
// - Mode 1 is one-shot, mode 2 periodic
// - One-shot stops at time-out; clear bit clears flags
// - RTC match reloads zero and keeps counting
// - Edge-count stops after programmed edges
// - Masks gate each source; write one clears
// - Configuration 4 to 7 means 16-bit
// - Each selected edge decrements the edge counter, except the match edge, which reloads it
package timer_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] OFS_CFG     = 8'h00;
	localparam logic [7:0] OFS_MODE_A  = 8'h04;
	localparam logic [7:0] OFS_MODE_B  = 8'h08;
	localparam logic [7:0] OFS_CTL     = 8'h0c;
	localparam logic [7:0] OFS_IMR     = 8'h18;
	localparam logic [7:0] OFS_RIS     = 8'h1c;
	localparam logic [7:0] OFS_MIS     = 8'h20;
	localparam logic [7:0] OFS_ICR     = 8'h24;
	localparam logic [7:0] OFS_ILR_A   = 8'h28;
	localparam logic [7:0] OFS_ILR_B   = 8'h2c;
	localparam logic [7:0] OFS_MATCH_A = 8'h30;
	localparam logic [7:0] OFS_MATCH_B = 8'h34;
	localparam logic [7:0] OFS_PRE_A   = 8'h38;
	localparam logic [7:0] OFS_PRE_B   = 8'h3c;
	localparam logic [7:0] OFS_TV_A    = 8'h48;
	localparam logic [7:0] OFS_TV_B    = 8'h4c;
	// ==========================================
	// Fields and codes
	localparam logic [2:0] CFG_32  = 3'h0;
	localparam logic [2:0] CFG_RTC = 3'h1;
	localparam int         CFG_16  = 2;
	localparam logic [1:0] MR_ONESHOT  = 2'h1;
	localparam logic [1:0] MR_PERIODIC = 2'h2;
	localparam logic [1:0] MR_CAPTURE  = 2'h3;
	localparam int MODE_CMR = 2;
	localparam int MODE_AMS = 3;
	localparam int CTL_SPAN   = 8;
	localparam int CTL_EN     = 0;
	localparam int CTL_STALL  = 1;
	localparam int CTL_EVT    = 2;
	localparam int CTL_RTCIGN = 4;
	localparam int CTL_PWML   = 6;
	localparam logic [1:0] EVT_RISE = 2'h0;
	localparam logic [1:0] EVT_FALL = 2'h1;
	localparam int INT_SPAN = 8;
	localparam int IB_TO    = 0;
	localparam int IB_CM    = 1;
	localparam int IB_CE    = 2;
	localparam int IB_RTC   = 3;
	// ==========================================
	// Reset values and limits
	localparam logic [31:0] LIM32     = 32'hffffffff;
	localparam logic [31:0] LIM16     = 32'h0000ffff;
	localparam logic [31:0] RTC_START = 32'h00000001;
	localparam int          RTC_DIV_DEFAULT = 32768;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// ==========================================
	// Carriers
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} axi_in_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_out_t;
	typedef struct packed {
		logic [3:0]  mode;
		logic        en;
		logic        stall;
		logic [1:0]  evt;
		logic        pwml;
		logic [31:0] ilr;
		logic [31:0] match;
		logic [7:0]  pre;
		logic [31:0] cnt;
		logic [7:0]  pcnt;
		logic [15:0] cap;
		logic        pwm_lvl;
	} half_t;
	typedef struct packed {
		logic [2:0]  cfg;
		logic        rtc_ign;
		logic [15:0] imr;
		logic [15:0] raw;
		half_t [1:0] h;
		logic [15:0] rtc_div;
		logic [1:0]  ccp_s1;
		logic [1:0]  ccp_s2;
		logic [1:0]  ccp_prev;
		logic [1:0]  pwm_out;
		logic        irq;
		logic        aw_full;
		logic [7:0]  aw_addr;
		logic        w_full;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		axi_out_t    ao;
	} state_t;
endpackage : timer_pkg

//--- hw/general_purpose_timer.sv
// General purpose timer: two 16-bit halves or one 32-bit counter, with
// capture, PWM and RTC. Assumes an AXI4-Lite master on i_clock and
// capture pins from outside the clock domain.
`timescale 1ns/1ps
module general_purpose_timer
	import timer_pkg::*;
#(
	parameter int RTC_DIV = RTC_DIV_DEFAULT
) (
	input  wire logic       i_clock,
	input  wire logic       i_rstn,
	input  wire axi_in_t    i_axi,
	output axi_out_t        o_axi,
	input  wire logic [1:0] i_ccp,
	input  wire logic       i_debug_halt,
	output logic [1:0]      o_pwm,
	output logic            o_interrupt
);
	localparam logic [15:0] DIV_LAST = 16'(RTC_DIV - 1);

	state_t      st_reg;
	state_t      st_next;
	half_t       h0;
	half_t       h1;
	logic [1:0]  rise;
	logic [1:0]  fall;
	logic [1:0]  edge_hit;
	logic        is16;
	logic        is_rtc;
	logic        rtc_tick;
	logic        do_wr;
	logic        a_et;
	logic        a_ec;
	logic        a_pwm;
	logic        a_os;

	// ==========================================
	// Edge detection after synchroniser
	assign h0     = st_reg.h[0];
	assign h1     = st_reg.h[1];
	assign rise   = st_reg.ccp_s2 & ~st_reg.ccp_prev;
	assign fall   = ~st_reg.ccp_s2 & st_reg.ccp_prev;
	assign is16   = st_reg.cfg[CFG_16];
	assign is_rtc = st_reg.cfg == CFG_RTC;
	assign do_wr  = st_reg.aw_full & st_reg.w_full & ~st_reg.ao.bvalid;

	for (genvar g = 0; g < 2; g++) begin : g_edge
		// Reserved event code counts both edges
		assign edge_hit[g] = (st_reg.h[g].evt == EVT_RISE) ? rise[g] :
			(st_reg.h[g].evt == EVT_FALL) ? fall[g] : (rise[g] | fall[g]);
	end

	// Pin clock divided to one tick per second
	assign rtc_tick = is_rtc & h0.en & rise[0] & (st_reg.rtc_div == DIV_LAST);

	assign a_et  = is16 & h0.mode[1:0] == MR_CAPTURE & h0.mode[MODE_CMR];
	assign a_ec  = is16 & h1.mode[1:0] == MR_CAPTURE & ~h1.mode[MODE_CMR];
	assign a_pwm = is16 & h0.mode[MODE_AMS] & ~h0.mode[MODE_CMR] & h0.mode[1:0] == MR_PERIODIC;
	assign a_os  = (is16 | st_reg.cfg == CFG_32) & h0.mode == {2'h0, MR_ONESHOT};

	// ==========================================
	// Register access helpers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				old[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return old;
	endfunction : merge

	function automatic logic [31:0] tval(input state_t s, input int i);
		logic [31:0] lim;
		lim = (s.cfg[CFG_16] || i == 1) ? LIM16 : LIM32;
		// Edge-time shows the held capture, other modes the live count
		if (s.cfg[CFG_16] && s.h[i].mode[1:0] == MR_CAPTURE && s.h[i].mode[MODE_CMR]) begin
			return {16'h0, s.h[i].cap};
		end
		return s.h[i].cnt & lim;
	endfunction : tval

	function automatic logic [32:0] reg_read(input state_t s, input logic [7:0] a);
		logic [31:0] d;
		logic        ok;
		d  = '0;
		ok = 1'b1;
		case (a)
			OFS_CFG:     d[2:0] = s.cfg;
			OFS_MODE_A:  d[3:0] = s.h[0].mode;
			OFS_MODE_B:  d[3:0] = s.h[1].mode;
			OFS_CTL: begin
				for (int i = 0; i < 2; i++) begin
					d[i*CTL_SPAN+CTL_EN]         = s.h[i].en;
					d[i*CTL_SPAN+CTL_STALL]      = s.h[i].stall;
					d[i*CTL_SPAN+CTL_EVT +: 2]   = s.h[i].evt;
					d[i*CTL_SPAN+CTL_PWML]       = s.h[i].pwml;
				end
				d[CTL_RTCIGN] = s.rtc_ign;
			end
			OFS_IMR:     d[15:0] = s.imr;
			OFS_RIS:     d[15:0] = s.raw;
			OFS_MIS:     d[15:0] = s.raw & s.imr;
			OFS_ICR:     d = '0;
			OFS_ILR_A:   d = s.h[0].ilr;
			OFS_ILR_B:   d = s.h[1].ilr;
			OFS_MATCH_A: d = s.h[0].match;
			OFS_MATCH_B: d = s.h[1].match;
			OFS_PRE_A:   d[7:0] = s.h[0].pre;
			OFS_PRE_B:   d[7:0] = s.h[1].pre;
			OFS_TV_A:    d = tval(s, 0);
			OFS_TV_B:    d = tval(s, 1);
			default:     ok = 1'b0;
		endcase
		return {ok, d};
	endfunction : reg_read

	// ==========================================
	// Next state
	always_comb begin
		logic [15:0] set_f;
		logic [15:0] clr_f;
		logic [1:0]  wr_ilr;
		logic [31:0] nv;
		logic [31:0] lim;
		logic [31:0] cn;
		logic [32:0] rd;
		logic [1:0]  mr;
		logic        cmr;
		logic        pwm;
		logic        act;
		logic        frz;
		logic        tick;
		st_next = st_reg;
		set_f   = '0;
		clr_f   = '0;
		wr_ilr  = '0;
		nv      = '0;
		lim     = '0;
		cn      = '0;
		rd      = '0;
		mr      = '0;
		cmr     = 1'b0;
		pwm     = 1'b0;
		act     = 1'b0;
		frz     = 1'b0;
		tick    = 1'b0;

		st_next.ccp_s1   = i_ccp;
		st_next.ccp_s2   = st_reg.ccp_s1;
		st_next.ccp_prev = st_reg.ccp_s2;

		// Write channel: address and data taken in either order
		if (st_reg.ao.awready && i_axi.awvalid) begin
			st_next.aw_full = 1'b1;
			st_next.aw_addr = {i_axi.awaddr[7:2], 2'b00};
		end
		if (st_reg.ao.wready && i_axi.wvalid) begin
			st_next.w_full = 1'b1;
			st_next.wdata  = i_axi.wdata;
			st_next.wstrb  = i_axi.wstrb;
		end
		if (st_reg.ao.bvalid && i_axi.bready) begin
			st_next.ao.bvalid = 1'b0;
		end
		if (do_wr) begin
			st_next.aw_full   = 1'b0;
			st_next.w_full    = 1'b0;
			st_next.ao.bvalid = 1'b1;
			st_next.ao.bresp  = RESP_OKAY;
			rd = reg_read(st_reg, st_reg.aw_addr);
			nv = merge(rd[31:0], st_reg.wdata, st_reg.wstrb);
			// Reconfiguring while enabled is left to software
			case (st_reg.aw_addr)
				OFS_CFG:    st_next.cfg = nv[2:0];
				OFS_MODE_A: st_next.h[0].mode = nv[3:0];
				OFS_MODE_B: st_next.h[1].mode = nv[3:0];
				OFS_CTL: begin
					for (int i = 0; i < 2; i++) begin
						st_next.h[i].en    = nv[i*CTL_SPAN+CTL_EN];
						st_next.h[i].stall = nv[i*CTL_SPAN+CTL_STALL];
						st_next.h[i].evt   = nv[i*CTL_SPAN+CTL_EVT +: 2];
						st_next.h[i].pwml  = nv[i*CTL_SPAN+CTL_PWML];
					end
					st_next.rtc_ign = nv[CTL_RTCIGN];
				end
				OFS_IMR:     st_next.imr = nv[15:0];
				OFS_ICR:     clr_f = nv[15:0];
				OFS_ILR_A: begin
					st_next.h[0].ilr = nv;
					wr_ilr[0] = 1'b1;
				end
				OFS_ILR_B: begin
					st_next.h[1].ilr = nv & LIM16;
					wr_ilr[1] = 1'b1;
				end
				OFS_MATCH_A: st_next.h[0].match = nv;
				OFS_MATCH_B: st_next.h[1].match = nv & LIM16;
				OFS_PRE_A:   st_next.h[0].pre = nv[7:0];
				OFS_PRE_B:   st_next.h[1].pre = nv[7:0];
				OFS_RIS, OFS_MIS, OFS_TV_A, OFS_TV_B: ;
				default:     st_next.ao.bresp = RESP_SLVERR;
			endcase
		end

		// Read channel
		if (st_reg.ao.arready && i_axi.arvalid) begin
			rd = reg_read(st_reg, {i_axi.araddr[7:2], 2'b00});
			st_next.ao.rvalid = 1'b1;
			st_next.ao.rdata  = rd[31:0];
			st_next.ao.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (st_reg.ao.rvalid && i_axi.rready) begin
			st_next.ao.rvalid = 1'b0;
		end

		// RTC divider runs on synchronised pin edges
		if (is_rtc && st_reg.h[0].en) begin
			if (rise[0]) begin
				st_next.rtc_div = (st_reg.rtc_div == DIV_LAST) ? '0 : st_reg.rtc_div + 16'h1;
			end
		end else begin
			st_next.rtc_div = '0;
		end

		// ==========================================
		// Counters of both halves
		for (int i = 0; i < 2; i++) begin
			lim = (is16 || i == 1) ? LIM16 : LIM32;
			mr  = st_reg.h[i].mode[1:0];
			cmr = st_reg.h[i].mode[MODE_CMR];
			pwm = st_reg.h[i].mode[MODE_AMS] & ~cmr & (mr == MR_PERIODIC);
			act = is16 || (st_reg.cfg == CFG_32 && i == 0);
			frz = i_debug_halt & st_reg.h[i].stall & ~(is_rtc & st_reg.rtc_ign);
			cn  = st_reg.h[i].cnt;
			if (!st_reg.h[i].en) begin
				st_next.h[i].cnt     = (is_rtc && i == 0) ? RTC_START : st_reg.h[i].ilr & lim;
				st_next.h[i].pcnt    = st_reg.h[i].pre;
				st_next.h[i].pwm_lvl = 1'b0;
			end else if (is_rtc && i == 0) begin
				if (rtc_tick && !frz) begin
					if (cn == st_reg.h[i].match) begin
						st_next.h[i].cnt = '0;
						set_f[IB_RTC]    = 1'b1;
					end else begin
						st_next.h[i].cnt = cn + 32'h1;
					end
				end
			end else if (act && !frz) begin
				if (is16 && mr == MR_CAPTURE && !cmr) begin
					if (edge_hit[i]) begin
						nv = (cn - 32'h1) & lim;
						if (nv == (st_reg.h[i].match & lim)) begin
							set_f[i*INT_SPAN+IB_CM] = 1'b1;
							st_next.h[i].cnt = st_reg.h[i].ilr & lim;
							st_next.h[i].en  = 1'b0;
						end else begin
							st_next.h[i].cnt = nv;
						end
					end
				end else if (is16 && mr == MR_CAPTURE) begin
					// No prescaler: one step per clock
					st_next.h[i].cnt = (cn == '0) ? st_reg.h[i].ilr & lim : cn - 32'h1;
					if (edge_hit[i]) begin
						st_next.h[i].cap = cn[15:0];
						set_f[i*INT_SPAN+IB_CE] = 1'b1;
					end
				end else if (mr == MR_ONESHOT || mr == MR_PERIODIC) begin
					tick = !is16 || st_reg.h[i].pcnt == '0;
					if (is16) begin
						st_next.h[i].pcnt = (st_reg.h[i].pcnt == '0) ? st_reg.h[i].pre
							: st_reg.h[i].pcnt - 8'h1;
					end
					if (tick) begin
						if (cn == '0) begin
							st_next.h[i].cnt = st_reg.h[i].ilr & lim;
							if (!pwm) begin
								set_f[i*INT_SPAN+IB_TO] = 1'b1;
								if (mr == MR_ONESHOT) begin
									st_next.h[i].en = 1'b0;
								end
							end
						end else begin
							st_next.h[i].cnt = cn - 32'h1;
						end
					end
					if (pwm) begin
						if (cn == (st_reg.h[i].ilr & lim)) begin
							st_next.h[i].pwm_lvl = 1'b1;
						end else if (cn == (st_reg.h[i].match & lim)) begin
							st_next.h[i].pwm_lvl = 1'b0;
						end
					end
				end
			end
			// Running counter picks up a new interval at once
			if (wr_ilr[i] && st_reg.h[i].en && !(is_rtc && i == 0)) begin
				st_next.h[i].cnt = st_next.h[i].ilr & lim;
			end
			st_next.pwm_out[i] = st_next.h[i].pwm_lvl ^ st_next.h[i].pwml;
		end

		// Set wins over a clear in the same cycle
		st_next.raw        = (st_reg.raw & ~clr_f) | set_f;
		st_next.irq        = |(st_next.raw & st_next.imr);
		st_next.ao.awready = ~st_next.aw_full;
		st_next.ao.wready  = ~st_next.w_full;
		st_next.ao.arready = ~st_next.ao.rvalid;
	end

	// ==========================================
	// State register
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			st_reg            <= '0;
			st_reg.h[0].ilr   <= LIM32;
			st_reg.h[0].match <= LIM32;
			st_reg.h[0].cnt   <= LIM32;
			st_reg.h[1].ilr   <= LIM16;
			st_reg.h[1].match <= LIM16;
			st_reg.h[1].cnt   <= LIM16;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_axi       = st_reg.ao;
	assign o_pwm       = st_reg.pwm_out;
	assign o_interrupt = st_reg.irq;

	// ==========================================
	// Checks on half A; edge count watched on half B
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);

	chk_et_decrement: assert property (
		a_et && h0.en && h0.cnt != '0 && !i_debug_halt && !do_wr |=> h0.cnt == $past(h0.cnt) - 32'h1)
		else $error("edge-time count did not step by one");
	chk_et_reload: assert property (
		a_et && h0.en && h0.cnt == '0 && !i_debug_halt && !do_wr |=> h0.cnt == ($past(h0.ilr) & LIM16))
		else $error("edge-time count did not reload at zero");
	chk_et_capture: assert property (
		a_et && h0.en && edge_hit[0] && !i_debug_halt && !do_wr
		|=> h0.cap == $past(h0.cnt[15:0]) && st_reg.raw[IB_CE])
		else $error("capture value or event flag wrong");
	chk_cap_hold: assert property (
		!edge_hit[0] |=> $stable(h0.cap))
		else $error("capture changed without an edge");
	chk_ilr_next: assert property (
		do_wr && st_reg.aw_addr == OFS_ILR_A && st_reg.wstrb == 4'hf && a_et && h0.en
		|=> h0.cnt == ($past(st_reg.wdata) & LIM16))
		else $error("load write not applied next cycle");
	chk_pwm_quiet: assert property (
		a_pwm && h0.en && !st_reg.raw[IB_TO] && !do_wr |=> !st_reg.raw[IB_TO])
		else $error("status flag set in pwm mode");
	chk_pwm_rise: assert property (
		a_pwm && h0.en && h0.cnt == (h0.ilr & LIM16) && !i_debug_halt && !do_wr
		|=> o_pwm[0] == ~h0.pwml)
		else $error("pwm output not asserted at start value");
	chk_ec_stop: assert property (
		a_ec && h1.en && edge_hit[1] && !i_debug_halt && !do_wr
		&& ((h1.cnt - 32'h1) & LIM16) == (h1.match & LIM16)
		|=> !h1.en && st_reg.raw[INT_SPAN+IB_CM] ##1 !h1.en || $past(do_wr))
		else $error("edge count did not stop at match");
	chk_oneshot_stop: assert property (
		a_os && h0.en && h0.cnt == '0 && (h0.pcnt == '0 || !is16) && !i_debug_halt && !do_wr
		|=> !h0.en && st_reg.raw[IB_TO])
		else $error("one-shot did not stop at time-out");
	chk_rtc_wrap: assert property (
		rtc_tick && h0.cnt == h0.match && !i_debug_halt && !do_wr
		|=> h0.cnt == '0 && st_reg.raw[IB_RTC] ##1 h0.en)
		else $error("rtc did not wrap to zero");
	chk_irq_mask: assert property (
		o_interrupt == |(st_reg.raw & st_reg.imr))
		else $error("interrupt disagrees with masked status");
	chk_sync_depth: assert property (
		rise[0] |-> $past(i_ccp[0], 2) && !$past(i_ccp[0], 3))
		else $error("capture edge seen without two-stage sync");

	cov_et_capture: cover property (a_et && h0.en && edge_hit[0]);
	cov_ec_done:    cover property (a_ec && $fell(h1.en) && st_reg.raw[INT_SPAN+IB_CM]);
	cov_pwm_cycle:  cover property ($rose(o_pwm[0]) ##[1:300] $fell(o_pwm[0]));
	cov_rtc_match:  cover property (rtc_tick && h0.cnt == h0.match);
endmodule : general_purpose_timer

//--- testbench/capture_pin_source.sv
// Model of the world outside the capture pins: single edges on demand
// and a scaled-down stand-in for the slow RTC reference on pin 0.
// Assumes the bench calls its task just after a rising clock edge.
`timescale 1ns/1ps
module capture_pin_source #(
	parameter int RTC_HALF = 4
) (
	input  wire logic       i_clock,
	output logic [1:0]      o_ccp
);
	logic rtc_on;
	int   phase;

	initial begin
		o_ccp  = 2'h0;
		rtc_on = 1'b0;
		phase  = 0;
	end

	// ==========================================
	// Reference clock
	// Runs only while enabled; otherwise only flip moves pin 0
	always @(posedge i_clock) begin
		if (rtc_on) begin
			phase <= (phase == RTC_HALF - 1) ? 0 : phase + 1;
			if (phase == RTC_HALF - 1) begin
				o_ccp[0] <= ~o_ccp[0];
			end
		end
	end

	task automatic flip(input int idx);
		@(posedge i_clock);
		o_ccp[idx] <= ~o_ccp[idx];
	endtask : flip
endmodule : capture_pin_source

//--- testbench/tb_general_purpose_timer_capture_pwm.sv
// Self-checking bench of the general purpose timer over AXI4-Lite.
// Assumes timer_pkg and the capture pin source model are compiled first.
`timescale 1ns/1ps
module tb_general_purpose_timer_capture_pwm
	import timer_pkg::*;
();
	logic        i_clock = 1'b0;
	logic        i_rstn;
	axi_in_t     axi_in;
	axi_out_t    o_axi;
	logic [1:0]  ccp;
	logic [1:0]  pwm;
	logic        irq;
	int          bad_count;
	int          tests_run;
	int          cycles = 0;
	logic        halt;
	logic [3:0]  strb;
	int          n;
	int          ilr;
	int          k;
	int          cnt;
	int          c1;
	int          c2;
	logic [31:0] seed;
	logic [31:0] v;
	logic [31:0] t1;
	logic [1:0]  r;

	general_purpose_timer #(.RTC_DIV(4)) uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_axi(axi_in), .o_axi(o_axi),
		.i_ccp(ccp), .i_debug_halt(halt), .o_pwm(pwm), .o_interrupt(irq));
	capture_pin_source #(.RTC_HALF(4)) src (.i_clock(i_clock), .o_ccp(ccp));

	always #2.5 i_clock = ~i_clock;

	// Whole run needs roughly 1500 cycles
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			bad_count++;
			summarize();
		end
	end

	// ==========================================
	// Helpers
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xorshift

	function automatic bit sel_edge(input int evt, input logic lvl);
		return (evt >= 2) || ((evt == 0) == lvl);
	endfunction : sel_edge

	function automatic int pwm_high(input int ld, input int mt, input bit pl, input int per);
		return pl ? (mt + 1) * per : (ld - mt) * per;
	endfunction : pwm_high

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw_p;
		bit w_p;
		@(posedge i_clock);
		axi_in.awaddr  <= {24'h0, a};
		axi_in.wdata   <= d;
		axi_in.wstrb   <= strb;
		axi_in.awvalid <= 1'b1;
		axi_in.wvalid  <= 1'b1;
		axi_in.bready  <= 1'b1;
		aw_p = 1'b1;
		w_p  = 1'b1;
		r    = 2'bxx;
		// Only the bench timeout ends a wait
		forever begin
			@(posedge i_clock);
			if (aw_p && o_axi.awready === 1'b1) begin
				aw_p = 1'b0;
				axi_in.awvalid <= 1'b0;
			end
			if (w_p && o_axi.wready === 1'b1) begin
				w_p = 1'b0;
				axi_in.wvalid <= 1'b0;
			end
			if (o_axi.bvalid === 1'b1) begin
				r = o_axi.bresp;
				axi_in.bready <= 1'b0;
				break;
			end
		end
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask : wr

	task automatic rd(input logic [7:0] a);
		bit ar_p;
		@(posedge i_clock);
		axi_in.araddr  <= {24'h0, a};
		axi_in.arvalid <= 1'b1;
		axi_in.rready  <= 1'b1;
		ar_p = 1'b1;
		r    = 2'bxx;
		v    = 'x;
		forever begin
			@(posedge i_clock);
			if (ar_p && o_axi.arready === 1'b1) begin
				ar_p = 1'b0;
				axi_in.arvalid <= 1'b0;
			end
			if (o_axi.rvalid === 1'b1) begin
				r = o_axi.rresp;
				v = o_axi.rdata;
				axi_in.rready <= 1'b0;
				break;
			end
		end
	endtask : rd

	task automatic rdk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(nm, e, v & m);
	endtask : rdk

	task automatic wait_int(input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge i_clock);
			if (irq === 1'b1) begin
				break;
			end
		end
	endtask : wait_int

	task automatic pwm_meas(input int ld, input bit pl);
		int h;
		h = 0;
		repeat (40) @(posedge i_clock);
		repeat ((ld + 1) * 4) begin
			@(posedge i_clock);
			h += int'(pwm[0] === 1'b1);
		end
		chk("pwm_high", 32'(pwm_high(ld, 3, pl, 4)), 32'(h));
		chk("pwm_idle", 32'h0, {31'h0, pwm[1]});
	endtask : pwm_meas

	task automatic summarize();
		if (bad_count == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	// ==========================================
	// Main sequence
	initial begin
		seed      = 32'hb71d;
		bad_count = 0;
		tests_run = 0;
		halt      = 1'b0;
		strb      = 4'hf;
		i_rstn    = 1'b0;
		axi_in    = '0;
		repeat (20) @(posedge i_clock);
		i_rstn <= 1'b1;
		@(posedge i_clock);
		rdk("cfg", OFS_CFG, 32'h7, 32'h0);
		rdk("ilr_a", OFS_ILR_A, '1, 32'hffffffff);
		rdk("ilr_b", OFS_ILR_B, '1, 32'h0000ffff);
		rd(8'h10);
		chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		// Byte strobes: only the two low lanes may land
		t1   = xorshift();
		strb = 4'h3;
		wr(OFS_MATCH_A, t1);
		strb = 4'hf;
		rdk("match_strb", OFS_MATCH_A, '1, {16'hffff, t1[15:0]});
		// 32-bit one-shot, then periodic, then masked
		ilr = 20 + int'(xorshift() % 20);
		wr(OFS_MODE_A, 32'h1);
		wr(OFS_ILR_A, 32'(ilr));
		wr(OFS_IMR, 32'h1);
		wr(OFS_CTL, 32'h1);
		wait_int(200);
		chk("oneshot_time", 32'h1, 32'(n >= ilr - 3 && n <= ilr + 3));
		rdk("oneshot_stop", OFS_CTL, 32'h1, 32'h0);
		wr(OFS_ICR, 32'h1);
		rdk("ris_to", OFS_RIS, 32'h1, 32'h0);
		chk("irq_clr", 32'h0, {31'h0, irq});
		wr(OFS_MODE_A, 32'h2);
		wr(OFS_CTL, 32'h3);
		wait_int(200);
		wr(OFS_ICR, 32'h1);
		wait_int(200);
		chk("periodic", 32'h1, 32'(n < 200));
		wr(OFS_IMR, 32'h0);
		repeat (2 * ilr) @(posedge i_clock);
		rdk("ris_masked", OFS_RIS, 32'h1, 32'h1);
		chk("irq_masked", 32'h0, {31'h0, irq});
		// Halt with the stall bit set freezes the count
		halt <= 1'b1;
		rd(OFS_TV_A);
		t1 = v;
		repeat (10) @(posedge i_clock);
		rdk("stall_hold", OFS_TV_A, '1, t1);
		halt <= 1'b0;
		wr(OFS_CTL, 32'h0);
		wr(OFS_ICR, 32'hffff);
		// Edge count on half B for event codes 0, 1 and 2
		wr(OFS_CFG, 32'h4 + (xorshift() % 4));
		wr(OFS_MODE_B, 32'h3);
		wr(OFS_IMR, 32'h200);
		for (int evt = 0; evt < 3; evt++) begin
			k = 1 + int'(xorshift() % 3);
			wr(OFS_CTL, 32'h0);
			wr(OFS_ICR, 32'h200);
			wr(OFS_ILR_B, 32'ha);
			wr(OFS_MATCH_B, 32'(10 - k));
			wr(OFS_CTL, 32'h100 | (32'(evt) << 10));
			cnt = 0;
			repeat (6) begin
				src.flip(1);
				repeat (6) @(posedge i_clock);
				cnt += int'(sel_edge(evt, src.o_ccp[1]));
				rdk("ris_cm", OFS_RIS, 32'h200, (cnt >= k) ? 32'h200 : 32'h0);
				rdk("tv_b", OFS_TV_B, 32'hffff, (cnt >= k) ? 32'ha : 32'(10 - cnt));
			end
			rdk("cnt_stop", OFS_CTL, 32'h100, 32'h0);
			chk("irq_cm", 32'h1, {31'h0, irq});
		end
		// Edge time on half A; prescale set to prove it is ignored
		wr(OFS_CTL, 32'h0);
		wr(OFS_MODE_A, 32'h7);
		wr(OFS_PRE_A, 32'hff);
		wr(OFS_ILR_A, 32'hffff);
		wr(OFS_IMR, 32'h4);
		wr(OFS_CTL, 32'h1);
		src.flip(0);
		c1 = cycles;
		repeat (8) @(posedge i_clock);
		rdk("ris_ce", OFS_RIS, 32'h4, 32'h4);
		rdk("mis_ce", OFS_MIS, 32'h4, 32'h4);
		rd(OFS_TV_A);
		t1 = v;
		repeat (20) @(posedge i_clock);
		rdk("tv_hold", OFS_TV_A, '1, t1);
		src.flip(0);
		src.flip(0);
		c2 = cycles;
		repeat (8) @(posedge i_clock);
		rd(OFS_TV_A);
		chk("tv_delta", 32'(c2 - c1), t1 - v);
		wr(OFS_ILR_A, 32'h1000);
		c1 = cycles;
		src.flip(0);
		src.flip(0);
		c2 = cycles;
		repeat (8) @(posedge i_clock);
		rd(OFS_TV_A);
		t1 = v + 32'(c2 - c1);
		chk("ilr_live", 32'h1, 32'(t1 >= 32'hffd && t1 <= 32'h1003));
		wr(OFS_CTL, 32'h0);
		wr(OFS_ICR, 32'hffff);
		// PWM on half A, period change while running, then inverted
		wr(OFS_MODE_A, 32'ha);
		wr(OFS_PRE_A, 32'h0);
		wr(OFS_MATCH_A, 32'h3);
		ilr = 9 + int'(xorshift() % 8);
		wr(OFS_ILR_A, 32'(ilr));
		wr(OFS_CTL, 32'h1);
		pwm_meas(ilr, 1'b0);
		ilr = 17 + int'(xorshift() % 8);
		wr(OFS_ILR_A, 32'(ilr));
		pwm_meas(ilr, 1'b0);
		wr(OFS_CTL, 32'h0);
		wr(OFS_CTL, 32'h41);
		pwm_meas(ilr, 1'b1);
		rdk("ris_pwm", OFS_RIS, 32'hffff, 32'h0);
		// RTC with a small divider
		wr(OFS_CTL, 32'h0);
		wr(OFS_CFG, {29'h0, CFG_RTC});
		wr(OFS_MATCH_A, 32'h2);
		wr(OFS_IMR, 32'h8);
		wr(OFS_CTL, 32'h1);
		src.rtc_on <= 1'b1;
		wait_int(300);
		chk("rtc_match", 32'h1, 32'(n < 300));
		wr(OFS_ICR, 32'h8);
		wait_int(300);
		chk("rtc_again", 32'h1, 32'(n < 300));
		rd(OFS_TV_A);
		chk("rtc_wrap", 32'h1, 32'(v < 32'h3));
		src.rtc_on <= 1'b0;
		summarize();
	end
endmodule : tb_general_purpose_timer_capture_pwm
